// ### rtl/scpm_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the clock/mode block
// Assumes: Byte-wide register data on a plain strobe port
// Notes:   Definitions only
`ifndef SCPM_REGS_SVH
`define SCPM_REGS_SVH

// ==========================================================
// Register offsets
`define SCPM_ADDR_W             4
`define SCPM_OFS_MODE           4'h0
`define SCPM_OFS_CTRL           4'h1
`define SCPM_OFS_STATUS         4'h2

// ==========================================================
// Clock mode register fields
`define SCPM_BIT_FULL_SPEED     0
`define SCPM_BIT_IDLE_SELECT    1
`define SCPM_BIT_HS_READY       2
`define SCPM_BIT_LS_READY       3
`define SCPM_BIT_FAST_WAKE      4
`define SCPM_DIV_LSB            5
`define SCPM_MODE_RESET         8'h03
`define SCPM_MODE_WMASK         8'hf3

// ==========================================================
// Control register fields
`define SCPM_BIT_KEEP_SYSCLK    0
`define SCPM_BIT_WDT_ENABLE     1
`define SCPM_CTRL_RESET         8'h02

// ==========================================================
// Timing
`define SCPM_XTAL_SETTLE_CYC    11'h400
`define SCPM_LS_SETTLE_CYC      2'h2

`endif

// ### rtl/scpm_pkg.sv
// Purpose: Types shared by the clock/mode block
// Assumes: Nothing
// Notes:   Constants live in scpm_regs.svh
package scpm_pkg;

  typedef enum logic [2:0] {
    SCPM_NORMAL     = 3'h0,
    SCPM_SLOW       = 3'h1,
    SCPM_IDLE_ON    = 3'h3,
    SCPM_IDLE_OFF   = 3'h2,
    SCPM_SLEEP_LT   = 3'h6,
    SCPM_SLEEP_DEEP = 3'h7
  } scpm_mode_type;

  typedef enum logic [1:0] {
    SCPM_SW_RUN  = 2'h0,
    SCPM_SW_WAIT = 2'h1,
    SCPM_SW_SYNC = 2'h3
  } scpm_sw_type;

endpackage

// ### rtl/scpm_clk_divider.sv
// Purpose: Enable pulses at high-speed clock divided by 2..64
// Assumes: One clock; enables model the divided clocks
// Notes:   Free-running counter, so every ratio shares one phase reference
`timescale 1ns/1ps
`default_nettype none

module scpm_clk_divider (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       run_in,
  output logic      [5:0] tick_out
);

  logic [5:0] count;
  logic [5:0] next_count;

  assign next_count = run_in ? count + 6'h01 : 6'h00;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 6'h00;
    end else begin
      count <= next_count;
    end
  end

  // tick_out[k] marks the end of a 2^(k+1) cycle period
  genvar k;
  generate
    for (k = 0; k < 6; k++) begin : g_tick
      assign tick_out[k] = run_in && (count[k:0] == {(k + 1){1'b1}});
    end
  endgenerate

endmodule

`default_nettype wire

// ### rtl/scpm_ready_timer.sv
// Purpose: Crystal settle counter behind the high-speed ready flag
// Assumes: Counts edges of the crystal as ref_clk_in cycles while running
// Notes:   Restarts whenever the oscillator is stopped
`timescale 1ns/1ps
`default_nettype none
`include "scpm_regs.svh"

module scpm_ready_timer (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic osc_on_in,
  input  wire logic use_xtal_in,
  output logic      ready_out
);

  logic [10:0] count;
  logic [10:0] next_count;

  // Internal RC needs no settle wait beyond one cycle
  assign next_count = !osc_on_in ? 11'h000 :
                      (count == `SCPM_XTAL_SETTLE_CYC) ? count : count + 11'h001;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count     <= 11'h000;
      ready_out <= 1'b0;
    end else begin
      count     <= next_count;
      ready_out <= osc_on_in && (!use_xtal_in || next_count == `SCPM_XTAL_SETTLE_CYC);
    end
  end

endmodule

`default_nettype wire

// ### rtl/scpm_clock_modes.sv
// Purpose: System clock selection and six-mode power control
// Assumes: Single clock stands in for all oscillators; clocks appear as enables
// Notes:   Halt and wake come from the CPU core as one-cycle pulses
// ==========================================================
// Overview of operation
// - Crystal or fast RC chosen by strap
// - Fast RC offers 4, 8 or 12 MHz
// - Fast RC frees crystal pins as I/O
// - Slow RC feeds system, watchdog, time base
// - System clock from fast, divided or slow
// - Normal mode divides fast clock 1 to 64
// - Switching to slow stops fast oscillator
// - Six modes; two run CPU, four halt
// - Slow mode runs CPU from slow RC
// - Halt with idle low sleeps; deep stops all
// - Light sleep keeps slow RC with watchdog
// - Halt, idle high, keep low: idle off
// - Idle off stops system oscillator, slow runs
// - Divider codes 000/001 slow, else fast/64..2
// - Full-speed bit picks undivided, resets one
// - Idle high, keep high: idle with clock
// - Crystal ready waits 1024 cycles after wake
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "scpm_regs.svh"

module scpm_clock_modes (
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      use_xtal_cfg_in,
  input  wire logic [1:0]                rc_freq_cfg_in,
  input  wire logic [`SCPM_ADDR_W-1:0]   reg_addr_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic                      reg_write_in,
  input  wire logic                      reg_read_in,
  output logic      [7:0]                reg_rdata_out,
  input  wire logic                      halt_in,
  input  wire logic                      wake_in,
  output logic                           cpu_clk_en_out,
  output logic                           sys_clk_en_out,
  output logic                           slow_clk_en_out,
  output logic                           fast_osc_on_out,
  output logic                           xtal_osc_on_out,
  output logic                           rc_fast_on_out,
  output logic      [1:0]                rc_freq_sel_out,
  output logic                           xtal_pins_gpio_out,
  output logic                           wdt_clk_en_out,
  output logic                           time_base_clk_en_out,
  output logic      [2:0]                mode_out
);

  // ==========================================================
  // Registers
  logic [7:0]                clock_mode_register;
  logic [7:0]                ctrl_reg;
  logic [7:0]                next_rdata;
  scpm_pkg::scpm_mode_type   mode;
  scpm_pkg::scpm_mode_type   next_mode;
  scpm_pkg::scpm_sw_type     sw_state;
  scpm_pkg::scpm_sw_type     next_sw_state;
  logic                      xtal_cfg;
  logic [1:0]                rc_cfg;
  logic                      cfg_taken;
  logic [3:0]                active_sel;
  logic [3:0]                next_active_sel;
  logic [1:0]                ls_count;
  logic                      ls_ready;

  // ==========================================================
  // Decode
  wire        full_speed_select   = clock_mode_register[`SCPM_BIT_FULL_SPEED];
  wire        halt_idle_select    = clock_mode_register[`SCPM_BIT_IDLE_SELECT];
  wire [2:0]  divider_select_code = clock_mode_register[7:`SCPM_DIV_LSB];
  wire        idle_keep_sysclk    = ctrl_reg[`SCPM_BIT_KEEP_SYSCLK];
  wire        wdt_enable          = ctrl_reg[`SCPM_BIT_WDT_ENABLE];
  wire        hit_mode            = reg_addr_in == `SCPM_OFS_MODE;
  wire        hit_ctrl            = reg_addr_in == `SCPM_OFS_CTRL;
  wire        hit_status          = reg_addr_in == `SCPM_OFS_STATUS;

  // ==========================================================
  // Clock source selection
  // Requested source: 4'hf = undivided, 4'h8 = slow, 0..5 = divide 2^(n+1)
  wire        want_slow   = !full_speed_select && (divider_select_code[2:1] == 2'b00);
  wire [3:0]  div_index   = 4'h7 - {1'b0, divider_select_code};
  wire [3:0]  want_sel    = full_speed_select ? 4'hf :
                            want_slow ? 4'h8 : div_index;
  wire        running     = (mode == scpm_pkg::SCPM_NORMAL) || (mode == scpm_pkg::SCPM_SLOW);
  wire        sys_osc_run = running || (mode == scpm_pkg::SCPM_IDLE_ON);
  // Slow mode only once the slow source is both requested and in use
  wire        slow_settled = (active_sel == 4'h8) && (want_sel == 4'h8);

  // ==========================================================
  // Oscillator control
  // Fast oscillator runs only while the fast clock is wanted or still selected
  wire        fast_needed = sys_osc_run && (mode != scpm_pkg::SCPM_SLOW) &&
                            (!want_slow || active_sel != 4'h8);
  // Held off until the strap is known, so a crystal part never flags ready early
  wire        fast_run    = fast_needed && cfg_taken;
  wire        slow_on     = (mode != scpm_pkg::SCPM_SLEEP_DEEP) &&
                            !((mode == scpm_pkg::SCPM_SLEEP_LT) && !wdt_enable);

  // ==========================================================
  // Tick sources
  wire [5:0]  div_tick;
  wire        fast_ready;
  wire        slow_tick   = slow_on && ls_ready;
  wire        cur_tick    = (active_sel == 4'hf) ? fast_ready :
                            (active_sel == 4'h8) ? slow_tick :
                            div_tick[active_sel[2:0]];
  wire        new_tick    = (want_sel == 4'hf) ? fast_ready :
                            (want_sel == 4'h8) ? slow_tick :
                            div_tick[want_sel[2:0]];

  scpm_clk_divider u_div (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (fast_ready),
    .tick_out   (div_tick)
  );

  scpm_ready_timer u_ready (
    .ref_clk_in  (ref_clk_in),
    .reset_n_in  (reset_n_in),
    .osc_on_in   (fast_run),
    .use_xtal_in (xtal_cfg),
    .ready_out   (fast_ready)
  );

  // ==========================================================
  // Glitch-free switch: finish current period, then start on new one
  always_comb begin
    next_sw_state   = sw_state;
    next_active_sel = active_sel;
    case (sw_state)
      scpm_pkg::SCPM_SW_RUN: begin
        if (want_sel != active_sel) begin
          next_sw_state = scpm_pkg::SCPM_SW_WAIT;
        end
      end
      scpm_pkg::SCPM_SW_WAIT: begin
        if (cur_tick || !sys_osc_run) begin
          next_sw_state = scpm_pkg::SCPM_SW_SYNC;
        end
      end
      scpm_pkg::SCPM_SW_SYNC: begin
        if (new_tick || !sys_osc_run) begin
          next_active_sel = want_sel;
          next_sw_state   = scpm_pkg::SCPM_SW_RUN;
        end
      end
      default: next_sw_state = scpm_pkg::SCPM_SW_RUN;
    endcase
  end

  // ==========================================================
  // Mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      scpm_pkg::SCPM_NORMAL, scpm_pkg::SCPM_SLOW: begin
        if (halt_in) begin
          if (!halt_idle_select) begin
            next_mode = wdt_enable ? scpm_pkg::SCPM_SLEEP_LT
                                   : scpm_pkg::SCPM_SLEEP_DEEP;
          end else if (idle_keep_sysclk) begin
            next_mode = scpm_pkg::SCPM_IDLE_ON;
          end else begin
            next_mode = scpm_pkg::SCPM_IDLE_OFF;
          end
        end else begin
          next_mode = slow_settled ? scpm_pkg::SCPM_SLOW
                                   : scpm_pkg::SCPM_NORMAL;
        end
      end
      scpm_pkg::SCPM_IDLE_ON, scpm_pkg::SCPM_IDLE_OFF,
      scpm_pkg::SCPM_SLEEP_LT, scpm_pkg::SCPM_SLEEP_DEEP: begin
        if (wake_in) begin
          next_mode = slow_settled ? scpm_pkg::SCPM_SLOW
                                   : scpm_pkg::SCPM_NORMAL;
        end
      end
      default: next_mode = scpm_pkg::SCPM_NORMAL;
    endcase
  end

  // ==========================================================
  // Read mux; status bits reflect live ready flags
  wire [7:0] mode_view = {clock_mode_register[7:4], ls_ready, fast_ready,
                          clock_mode_register[1:0]};
  assign next_rdata = !reg_read_in ? 8'h00 :
                      hit_mode   ? mode_view :
                      hit_ctrl   ? ctrl_reg :
                      hit_status ? {5'h00, mode} : 8'h00;

  // ==========================================================
  // Register writes
  // Ready bits are live status and are masked off, never stored
  wire       wr_mode                  = reg_write_in && hit_mode;
  wire       wr_ctrl                  = reg_write_in && hit_ctrl;
  wire [7:0] next_clock_mode_register = wr_mode ? (reg_wdata_in & `SCPM_MODE_WMASK)
                                                : clock_mode_register;
  wire [7:0] next_ctrl_reg            = wr_ctrl ? {6'h00, reg_wdata_in[1:0]} : ctrl_reg;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clock_mode_register <= `SCPM_MODE_RESET;
    end else begin
      clock_mode_register <= next_clock_mode_register;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= `SCPM_CTRL_RESET;
    end else begin
      ctrl_reg <= next_ctrl_reg;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ==========================================================
  // State flops
  // Switch state and active source move on the same edge
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode <= scpm_pkg::SCPM_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw_state <= scpm_pkg::SCPM_SW_RUN;
    end else begin
      sw_state <= next_sw_state;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      active_sel <= 4'hf;
    end else begin
      active_sel <= next_active_sel;
    end
  end

  // ==========================================================
  // Straps and slow RC settle
  // Straps captured once after reset release, frozen thereafter
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xtal_cfg  <= 1'b0;
      rc_cfg    <= 2'h0;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      xtal_cfg  <= use_xtal_cfg_in;
      rc_cfg    <= rc_freq_cfg_in;
      cfg_taken <= 1'b1;
    end
  end

  // Slow RC settles in three cycles after it restarts
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ls_count <= 2'h0;
      ls_ready <= 1'b0;
    end else if (!slow_on) begin
      ls_count <= 2'h0;
      ls_ready <= 1'b0;
    end else if (ls_count != `SCPM_LS_SETTLE_CYC) begin
      ls_count <= ls_count + 2'h1;
    end else begin
      ls_ready <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  assign cpu_clk_en_out       = running && cur_tick && sw_state == scpm_pkg::SCPM_SW_RUN;
  assign sys_clk_en_out       = sys_osc_run && cur_tick;
  assign slow_clk_en_out      = slow_tick;
  assign wdt_clk_en_out       = slow_tick && wdt_enable;
  assign time_base_clk_en_out = slow_tick;
  assign fast_osc_on_out      = fast_run;
  assign xtal_osc_on_out      = fast_run && xtal_cfg;
  assign rc_fast_on_out       = fast_run && !xtal_cfg;
  assign rc_freq_sel_out      = rc_cfg;
  assign xtal_pins_gpio_out   = !xtal_cfg;
  assign mode_out             = mode;

endmodule

`default_nettype wire

// ### tb/scpm_clock_modes_properties.sv
// Purpose: Port-level properties of the clock and mode block
// Assumes: Mode codes as in scpm_pkg; halted modes all have bit 1 set
// Notes:   Bound onto scpm_clock_modes at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module scpm_clock_modes_properties (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       halt_in,
  input  wire logic       wake_in,
  input  wire logic       cpu_clk_en_out,
  input  wire logic       sys_clk_en_out,
  input  wire logic       slow_clk_en_out,
  input  wire logic       fast_osc_on_out,
  input  wire logic       xtal_osc_on_out,
  input  wire logic       rc_fast_on_out,
  input  wire logic       xtal_pins_gpio_out,
  input  wire logic       wdt_clk_en_out,
  input  wire logic       time_base_clk_en_out,
  input  wire logic [2:0] mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // ==========================================================
  // Mode entry and exit
  property p_halt_enters;
    halt_in && !mode_out[1] |=> mode_out[1] && !cpu_clk_en_out;
  endproperty
  a_halt_enters: assert property (p_halt_enters)
    else $error("halt did not stop the cpu");
  property p_wake_leaves;
    wake_in && mode_out[1] |=> !mode_out[1];
  endproperty
  a_wake_leaves: assert property (p_wake_leaves)
    else $error("wake did not resume a running mode");
  property p_halted_no_cpu;
    mode_out[1] |-> !cpu_clk_en_out;
  endproperty
  a_halted_no_cpu: assert property (p_halted_no_cpu)
    else $error("cpu tick while halted");

  // ==========================================================
  // Clocks per mode
  property p_deep_all_off;
    mode_out == 3'h7 |-> !slow_clk_en_out && !wdt_clk_en_out && !fast_osc_on_out;
  endproperty
  a_deep_all_off: assert property (p_deep_all_off)
    else $error("clock running in deep sleep");
  property p_light_slow_on;
    mode_out == 3'h6 |-> slow_clk_en_out && wdt_clk_en_out && !fast_osc_on_out;
  endproperty
  a_light_slow_on: assert property (p_light_slow_on)
    else $error("slow clock stopped in light sleep");
  property p_idle_off_clocks;
    mode_out == 3'h2 |-> !sys_clk_en_out && !fast_osc_on_out && time_base_clk_en_out;
  endproperty
  a_idle_off_clocks: assert property (p_idle_off_clocks)
    else $error("wrong clocks in clock-off idle");
  property p_slow_fast_off;
    mode_out == 3'h1 [*2] |-> !fast_osc_on_out;
  endproperty
  a_slow_fast_off: assert property (p_slow_fast_off)
    else $error("fast oscillator running in slow mode");
  property p_wdt_from_slow;
    wdt_clk_en_out |-> slow_clk_en_out;
  endproperty
  a_wdt_from_slow: assert property (p_wdt_from_slow)
    else $error("watchdog ticks without slow clock");
  property p_crystal_pins;
    xtal_osc_on_out |-> !xtal_pins_gpio_out && !rc_fast_on_out;
  endproperty
  a_crystal_pins: assert property (p_crystal_pins)
    else $error("crystal pins or sources in conflict");
endmodule

bind scpm_clock_modes scpm_clock_modes_properties u_props (
  .ref_clk_in, .reset_n_in, .halt_in, .wake_in, .cpu_clk_en_out, .sys_clk_en_out,
  .slow_clk_en_out, .fast_osc_on_out, .xtal_osc_on_out, .rc_fast_on_out,
  .xtal_pins_gpio_out, .wdt_clk_en_out, .time_base_clk_en_out, .mode_out
);

`default_nettype wire

// ### tb/test_system_clock_and_power_modes.sv
// Purpose: Self-checking bench for the clock and mode block
// Assumes: Fast RC strap for the table, crystal strap for the ready flag
// Notes:   Tick counts use 128-cycle windows so every ratio divides evenly
`timescale 1ns/1ps
`default_nettype none
`include "scpm_regs.svh"

module test_system_clock_and_power_modes;
  typedef struct packed {
    logic [7:0] mode_w;
    logic [7:0] ctrl_w;
    logic [2:0] run;
    logic [7:0] ticks;
    logic [2:0] halted;
    logic       sys_on;
  } scpm_row_type;

  logic       ref_clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       use_xtal   = 1'b0;
  logic [1:0] rc_freq    = 2'h2;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr_en      = 1'b0;
  logic       rd_en      = 1'b0;
  logic       halt       = 1'b0;
  logic       wake       = 1'b0;
  logic [7:0] rdata;
  logic       cpu_en, sys_en, slow_en, fast_on, xtal_on, rc_on, gpio, wdt_en, tb_en;
  logic [1:0] freq_sel;
  logic [2:0] mode;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cnt, sc;
  logic [7:0] exp_slow;
  // Rows: mode write, ctrl write, run mode, cpu ticks per 128, halted mode, idle sys clock
  scpm_row_type rows [14] = '{
    '{8'h03, 8'h00, 3'h0, 8'h80, 3'h2, 1'b0}, '{8'h03, 8'h03, 3'h0, 8'h80, 3'h3, 1'b1},
    '{8'h01, 8'h02, 3'h0, 8'h80, 3'h6, 1'b0}, '{8'h01, 8'h00, 3'h0, 8'h80, 3'h7, 1'b0},
    '{8'h40, 8'h02, 3'h0, 8'h02, 3'h6, 1'b0}, '{8'h60, 8'h02, 3'h0, 8'h04, 3'h6, 1'b0},
    '{8'h80, 8'h02, 3'h0, 8'h08, 3'h6, 1'b0}, '{8'ha0, 8'h02, 3'h0, 8'h10, 3'h6, 1'b0},
    '{8'hc0, 8'h02, 3'h0, 8'h20, 3'h6, 1'b0}, '{8'he0, 8'h00, 3'h0, 8'h40, 3'h7, 1'b0},
    '{8'h00, 8'h02, 3'h1, 8'h80, 3'h6, 1'b0}, '{8'h22, 8'h03, 3'h1, 8'h80, 3'h3, 1'b1},
    '{8'h02, 8'h00, 3'h1, 8'h80, 3'h2, 1'b0}, '{8'h03, 8'h03, 3'h0, 8'h80, 3'h3, 1'b1}};

  always #4 ref_clk_in = ~ref_clk_in;

  scpm_clock_modes dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .use_xtal_cfg_in(use_xtal),
    .rc_freq_cfg_in(rc_freq), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
    .halt_in(halt), .wake_in(wake), .cpu_clk_en_out(cpu_en), .sys_clk_en_out(sys_en),
    .slow_clk_en_out(slow_en), .fast_osc_on_out(fast_on), .xtal_osc_on_out(xtal_on),
    .rc_fast_on_out(rc_on), .rc_freq_sel_out(freq_sel), .xtal_pins_gpio_out(gpio),
    .wdt_clk_en_out(wdt_en), .time_base_clk_en_out(tb_en), .mode_out(mode));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk_in);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdx(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk_in);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic count(input int n);
    cnt = 0;
    sc = 0;
    repeat (n) begin
      @(negedge ref_clk_in);
      cnt += cpu_en;
      sc += sys_en;
    end
  endtask

  task automatic pulse(input logic w);
    @(posedge ref_clk_in);
    if (w) wake <= 1'b1;
    else halt <= 1'b1;
    @(posedge ref_clk_in);
    wake <= 1'b0;
    halt <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic x);
    reset_n_in <= 1'b0;
    use_xtal <= x;
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
  endtask

  task automatic conclude;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    do_reset(1'b0);
    chk({rc_on, xtal_on, gpio, 3'h0, freq_sel}, 8'ha2);
    rdx(`SCPM_OFS_MODE, 8'h0f);
    rdx(`SCPM_OFS_CTRL, `SCPM_CTRL_RESET);
    rdx(`SCPM_OFS_STATUS, 8'h00);
    rdx(4'h5, 8'h00);
    wr(`SCPM_OFS_MODE, 8'hf1);
    rdx(`SCPM_OFS_MODE, 8'hfd);
    pulse(1'b1);
    chk(8'(mode), 8'h00);
    foreach (rows[i]) begin
      wr(`SCPM_OFS_CTRL, rows[i].ctrl_w);
      wr(`SCPM_OFS_MODE, rows[i].mode_w);
      repeat (200) @(posedge ref_clk_in);
      count(128);
      chk(8'(mode), 8'(rows[i].run));
      chk(8'(cnt), rows[i].ticks);
      chk(8'(fast_on), 8'(rows[i].run == 3'h0));
      pulse(1'b0);
      chk(8'(mode), 8'(rows[i].halted));
      count(16);
      chk(8'(cnt), 8'h00);
      chk(8'(sc != 0), 8'(rows[i].sys_on));
      exp_slow = (rows[i].halted == 3'h7) ? 8'h00 : {5'h0, rows[i].ctrl_w[1], 2'h3};
      chk({5'h0, wdt_en, slow_en, tb_en}, exp_slow);
      pulse(1'b1);
      chk(8'(mode), 8'(rows[i].run));
    end
    // Crystal strap: ready flag waits for the settle count
    do_reset(1'b1);
    chk({5'h0, rc_on, xtal_on, gpio}, 8'h02);
    count(16);
    chk(8'(cnt), 8'h00);
    repeat (990) @(posedge ref_clk_in);
    rdx(`SCPM_OFS_MODE, 8'h0b);
    repeat (40) @(posedge ref_clk_in);
    rdx(`SCPM_OFS_MODE, 8'h0f);
    wr(`SCPM_OFS_CTRL, 8'h00);
    pulse(1'b0);
    chk(8'(mode), 8'h02);
    pulse(1'b1);
    rdx(`SCPM_OFS_MODE, 8'h0b);
    repeat (1030) @(posedge ref_clk_in);
    rdx(`SCPM_OFS_MODE, 8'h0f);
    conclude();
  end

  // Roughly three times the expected run length
  initial begin
    #160000;
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
